// *** bench/lbk_channel_sva.sv ***
// assertion checker for the loopback channel ports
`timescale 1ns/1ps
`default_nettype none
`include "lbk_map.svh"
module lbk_channel_sva
  import lbk_pkg::*;
#(
  parameter int EBUF_DEPTH = 4
) (
  // clock, reset and register port
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_RDATA_O,
  // parallel user side
  input wire logic [9:0] TX_WORD_I,
  input wire logic TX_VALID_I,
  input wire logic TX_TAKE_O,
  input wire logic [9:0] RX_WORD_O,
  input wire logic RX_VALID_O,
  // serial side
  input wire logic RX_SCLK_I,
  input wire logic RX_SDAT_I,
  input wire logic TX_SCLK_O,
  input wire logic TX_SDAT_O,
  input wire logic TX_OE_O
);
  logic [3:0] ctrl_reg;
  logic [9:0] word_reg;
  logic rx_sclk_reg;
  logic [7:0] rx_age_reg;
  logic far_w;
  logic fser_w;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // shadow selector, offered word and age of the last link clock rise
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_reg <= 4'h0;
      word_reg <= 10'h000;
      rx_sclk_reg <= 1'b0;
      rx_age_reg <= 8'hFF;
    end else begin
      if (REG_WR_I && REG_ADDR_I == `LBK_REG_CTRL) ctrl_reg <= REG_WDATA_I[3:0];
      word_reg <= TX_WORD_I;
      rx_sclk_reg <= RX_SCLK_I;
      if (RX_SCLK_I && !rx_sclk_reg) rx_age_reg <= 8'h00;
      else if (rx_age_reg != 8'hFF) rx_age_reg <= rx_age_reg + 8'h01;
    end
  end
  // far loop modes
  assign fser_w = ctrl_reg[2:0] == `LBK_MODE_FE_SER;
  assign far_w = fser_w || ctrl_reg[2:0] == `LBK_MODE_FE_PAR;
  a_rdata_idle: assert property (!REG_RD_I |=> REG_RDATA_O == 32'h0)
    else $error("read data not zero outside a read");
  a_far_no_take: assert property (far_w && $past(far_w) |-> !TX_TAKE_O)
    else $error("user word taken in a far loop");
  a_prbs_no_take: assert property (ctrl_reg[3] && $past(ctrl_reg[3]) |-> !TX_TAKE_O)
    else $error("user word taken while pattern runs");
  a_take_cause: assert property (TX_TAKE_O |-> $past(TX_VALID_I))
    else $error("take without offered word");
  a_take_bit0: assert property (TX_TAKE_O && TX_OE_O |-> TX_SCLK_O && TX_SDAT_O == word_reg[0])
    else $error("first serial bit wrong at take");
  a_nepar_quiet: assert property ((ctrl_reg[2:0] == `LBK_MODE_NE_PAR)[*4] |-> !TX_OE_O)
    else $error("serial drive on in near parallel loop");
  a_neser_drive: assert property ((ctrl_reg[2:0] == `LBK_MODE_NE_SER)[*4] |-> TX_OE_O)
    else $error("serial drive off in near serial loop");
  a_rx_pulse: assert property (RX_VALID_O |=> !RX_VALID_O)
    else $error("receive valid longer than one cycle");
  a_fser_clock: assert property (fser_w[*8] ##0 $rose(TX_SCLK_O) |-> rx_age_reg < 8'h08)
    else $error("far serial bit not on link clock");
endmodule : lbk_channel_sva
bind lbk_channel lbk_channel_sva #(.EBUF_DEPTH(EBUF_DEPTH)) chk_u (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .TX_WORD_I(TX_WORD_I), .TX_VALID_I(TX_VALID_I),
  .TX_TAKE_O(TX_TAKE_O), .RX_WORD_O(RX_WORD_O), .RX_VALID_O(RX_VALID_O),
  .RX_SCLK_I(RX_SCLK_I), .RX_SDAT_I(RX_SDAT_I), .TX_SCLK_O(TX_SCLK_O),
  .TX_SDAT_O(TX_SDAT_O), .TX_OE_O(TX_OE_O)
);
`default_nettype wire

// *** bench/lbk_link_partner.sv ***
// behavioural remote serial end for the loopback channel
`timescale 1ns/1ps
`default_nettype none
module lbk_link_partner
  import lbk_pkg::*;
(
  // channel transmit pins, watched
  input wire logic tx_sclk_i,
  input wire logic tx_sdat_i,
  input wire logic tx_oe_i,
  // channel receive pins, driven
  output logic rx_sclk_o,
  output logic rx_sdat_o,
  // last ten line bits, first bit in bit 0
  output lbk_word_t cap_o
);
  // link clock stands still between frames
  initial begin
    rx_sclk_o = 1'b0;
    rx_sdat_o = 1'b1;
    cap_o = 10'h000;
  end
  // shift in each driven bit mid-bit, where the clock falls and data is settled
  always @(negedge tx_sclk_i) begin
    if (tx_oe_i) cap_o <= {tx_sdat_i, cap_o[9:1]};
  end
  // receive pins stay idle outside send4, so the near serial loop needs
  // no equaliser or analog override
  // one channel looped on its recovered clock: dividers at one, transmit
  // buffer in use, no second channel to disturb
  // four groups sent verbatim, no correction inserted
  task automatic send4(input lbk_word_t a, b, c, d);
    lbk_word_t q[4];
    q = '{a, b, c, d};
    #3;
    foreach (q[i]) begin
      for (int k = 0; k < 10; k++) begin
        rx_sdat_o = q[i][k];
        #80 rx_sclk_o = 1'b1;
        #80 rx_sclk_o = 1'b0;
      end
    end
    rx_sdat_o = ~q[3][9]; // released line shows the inverse
  endtask : send4
endmodule : lbk_link_partner
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the loopback channel
`timescale 1ns/1ps
`default_nettype none
`include "lbk_map.svh"
module testbench
  import lbk_pkg::*;
;
  localparam lbk_word_t W_A = 10'h1A6;
  localparam lbk_word_t W_B = 10'h2D9;
  logic clk, rst_n, wr, rd, tx_valid, tx_take, rx_valid;
  logic rx_sclk, rx_sdat, tx_sclk, tx_sdat, tx_oe;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  lbk_word_t tx_word, rx_word, cap;
  int n_errors = 0;
  int n_compared = 0;
  int n_take = 0;
  lbk_channel #(.EBUF_DEPTH(4)) dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .TX_WORD_I(tx_word),
    .TX_VALID_I(tx_valid), .TX_TAKE_O(tx_take), .RX_WORD_O(rx_word),
    .RX_VALID_O(rx_valid), .RX_SCLK_I(rx_sclk), .RX_SDAT_I(rx_sdat),
    .TX_SCLK_O(tx_sclk), .TX_SDAT_O(tx_sdat), .TX_OE_O(tx_oe)
  );
  lbk_link_partner partner_u (
    .tx_sclk_i(tx_sclk), .tx_sdat_i(tx_sdat), .tx_oe_i(tx_oe),
    .rx_sclk_o(rx_sclk), .rx_sdat_o(rx_sdat), .cap_o(cap)
  );
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // count words taken from the user side
  always @(posedge clk) if (tx_take === 1'b1) n_take++;
  task automatic results();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic chk_reg(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_word(input string nm, input lbk_word_t e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read one register and compare the masked bits
  task automatic chk_rd(input string nm, input logic [7:0] a,
                        input logic [31:0] m, e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk_reg(nm, e, rdata & m);
  endtask : chk_rd
  task automatic set_mode(input logic [2:0] c);
    wr_reg(`LBK_REG_CTRL, {29'h0, c});
    repeat (450) @(posedge clk);
  endtask : set_mode
  // offer one word until it is taken
  task automatic send_user(input lbk_word_t w);
    @(posedge clk);
    tx_word <= w;
    tx_valid <= 1'b1;
    repeat (250) begin
      @(posedge clk);
      if (tx_take === 1'b1) break;
    end
    tx_valid <= 1'b0;
  endtask : send_user
  // wait for a word at the receive port (0) or on the line (1)
  task automatic expect_word(input string nm, input bit src,
                             input lbk_word_t w, input int lim);
    lbk_word_t got;
    got = ~w;
    repeat (lim) begin
      @(posedge clk);
      if (!src && rx_valid === 1'b1) got = rx_word;
      if (src) got = cap;
      if (got === w) break;
    end
    chk_word(nm, w, got);
  endtask : expect_word
  task automatic t_regs();
    chk_rd("ctrl", `LBK_REG_CTRL, 32'hF, 32'h0);
    chk_rd("errs", `LBK_REG_ERRS, 32'hFFFF, 32'h0);
    wr_reg(8'h40, 32'hF);
    chk_rd("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    chk_rd("ctrl", `LBK_REG_CTRL, 32'hF, 32'h0);
  endtask : t_regs
  // every selector code, reserved flag and serial drive
  task automatic t_codes();
    logic [2:0] c;
    logic [31:0] e;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      e = {27'h0, 1'b0, 1'b1, c != 3'h1, c[0] && c != 3'h1, 1'b0};
      wr_reg(`LBK_REG_CTRL, {29'h0, c});
      repeat (4) @(posedge clk);
      chk_rd("ctrl", `LBK_REG_CTRL, 32'hF, {29'h0, c});
      chk_rd("stat", `LBK_REG_STAT, 32'h1E, e);
    end
  endtask : t_codes
  task automatic t_near();
    lbk_word_t c0;
    set_mode(`LBK_MODE_NORMAL);
    fork
      send_user(W_A);
      expect_word("line word", 1'b1, W_A, 700);
    join
    set_mode(`LBK_MODE_NE_PAR);
    c0 = cap;
    fork
      send_user(W_B);
      expect_word("rx word", 1'b0, W_B, 400);
    join
    chk_word("line idle", c0, cap);
    set_mode(`LBK_MODE_NE_SER);
    fork
      send_user(W_A);
      expect_word("rx word", 1'b0, W_A, 1200);
      expect_word("line word", 1'b1, W_A, 1200);
    join
  endtask : t_near
  // pattern run: no errors after a clear, user word refused
  task automatic t_prbs();
    int t0;
    // switch inside an idle comma so the checker aligns on its tail
    repeat (100) @(posedge clk);
    wr_reg(`LBK_REG_CTRL, {28'h0, 1'b1, `LBK_MODE_NE_SER});
    @(posedge clk);
    tx_valid <= 1'b1;
    t0 = n_take;
    repeat (3000) @(posedge clk);
    wr_reg(`LBK_REG_ERRS, 32'h0);
    repeat (1000) @(posedge clk);
    chk_rd("errs", `LBK_REG_ERRS, 32'hFFFF, 32'h0);
    chk_rd("aligned", `LBK_REG_STAT, 32'h1, 32'h1);
    chk_reg("takes", 32'h0, 32'(n_take - t0));
  endtask : t_prbs
  task automatic t_far();
    int t0;
    set_mode(`LBK_MODE_FE_SER);
    t0 = n_take;
    fork
      partner_u.send4(`LBK_COMMA_NEG, W_B, `LBK_COMMA_NEG, `LBK_COMMA_NEG);
      expect_word("echo", 1'b1, W_B, 1200);
    join
    chk_reg("takes", 32'h0, 32'(n_take - t0));
    set_mode(`LBK_MODE_FE_PAR);
    t0 = n_take;
    fork
      partner_u.send4(`LBK_COMMA_NEG, `LBK_COMMA_POS, `LBK_COMMA_NEG,
                      `LBK_COMMA_NEG);
      expect_word("rx word", 1'b0, `LBK_COMMA_POS, 1500);
      expect_word("echo", 1'b1, `LBK_COMMA_POS, 1500);
    join
    chk_reg("takes", 32'h0, 32'(n_take - t0));
    tx_valid <= 1'b0;
  endtask : t_far
  // main sequence
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    tx_word = 10'h000;
    tx_valid = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_codes();
    t_near();
    t_prbs();
    t_far();
    results();
  end
  // watchdog against a hang
  initial begin
    #600000;
    n_errors++;
    results();
  end
endmodule : testbench
`default_nettype wire

// *** design/lbk_channel.sv ***
// serial transceiver channel with selectable loopback paths
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lbk_map.svh"

module lbk_channel
  import lbk_pkg::*;
#(
  parameter int EBUF_DEPTH = 4
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  // parallel user side
  input wire logic [9:0] TX_WORD_I,
  input wire logic TX_VALID_I,
  output logic TX_TAKE_O,
  output logic [9:0] RX_WORD_O,
  output logic RX_VALID_O,
  // serial link side
  input wire logic RX_SCLK_I,
  input wire logic RX_SDAT_I,
  output logic TX_SCLK_O,
  output logic TX_SDAT_O,
  output logic TX_OE_O
);
  localparam int AW = $clog2(EBUF_DEPTH);
  localparam logic [4:0] BIT_CYC = 5'(`LBK_BIT_CYC);
  localparam logic [4:0] HALF_CYC = 5'(`LBK_BIT_CYC / 2);

  // one prbs word: generate from state, or self-sync on received bits
  function automatic logic [16:0] prbs_step(input logic [6:0] st,
                                            input lbk_word_t rx,
                                            input logic use_rx);
    logic [6:0] s;
    lbk_word_t w;
    logic b;
    s = st;
    w = '0;
    for (int i = 0; i < 10; i++) begin
      b = s[6] ^ s[5];
      w[i] = b;
      s = {s[5:0], (use_rx ? rx[i] : b)};
    end
    return {s, w};
  endfunction : prbs_step

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // link inputs: two flops, third stage only for edge finding
  logic [2:0] rx_clk_reg;
  logic [1:0] rx_dat_reg;
  always_ff @(posedge CLK_I or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rx_clk_reg <= 3'h0;
      rx_dat_reg <= 2'h0;
    end else begin
      rx_clk_reg <= {rx_clk_reg[1:0], RX_SCLK_I};
      rx_dat_reg <= {rx_dat_reg[0], RX_SDAT_I};
    end
  end
  logic rx_rise;
  logic rx_fall;
  assign rx_rise = rx_clk_reg[1] & ~rx_clk_reg[2];
  assign rx_fall = ~rx_clk_reg[1] & rx_clk_reg[2];

  // control register and path decode
  lbk_ctrl_s ctrl_reg, ctrl_next;
  lbk_path_e path;
  logic mode_rsvd;
  always_comb begin
    mode_rsvd = 1'b0;
    case (ctrl_reg.mode)
      `LBK_MODE_NORMAL: path = LBK_PATH_NORMAL;
      `LBK_MODE_NE_PAR: path = LBK_PATH_NE_PAR;
      `LBK_MODE_NE_SER: path = LBK_PATH_NE_SER;
      `LBK_MODE_FE_SER: path = LBK_PATH_FE_SER;
      `LBK_MODE_FE_PAR: path = LBK_PATH_FE_PAR;
      default: begin
        path = LBK_PATH_NORMAL; // reserved codes run as normal
        mode_rsvd = 1'b1;
      end
    endcase
  end
  logic far_ser;
  logic far_loop;
  assign far_ser = (path == LBK_PATH_FE_SER);
  assign far_loop = far_ser || (path == LBK_PATH_FE_PAR);

  // bit divider for the locally timed transmitter
  logic [4:0] div_reg, div_next;
  always_comb begin
    div_next = (div_reg == BIT_CYC - 5'h1) ? 5'h0 : div_reg + 5'h1;
  end
  always_ff @(posedge CLK_I or negedge rst_sync_reg) begin
    if (!rst_sync_reg) div_reg <= 5'h0;
    else div_reg <= div_next;
  end
  logic tx_stb;
  logic tx_low;
  // far serial loop sends on the recovered rx clock
  assign tx_stb = far_ser ? rx_rise : (div_reg == 5'h0);
  assign tx_low = far_ser ? rx_fall : (div_reg == HALF_CYC);

  // elastic buffer between rx words and transmit loads
  lbk_word_t ebuf_mem [EBUF_DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] fill_reg, fill_next;
  logic ebuf_wr;
  logic ebuf_rd;
  logic ebuf_empty;
  logic ebuf_full;
  lbk_pword_s des_word;
  logic tx_load;
  assign ebuf_empty = (fill_reg == '0);
  assign ebuf_full = (fill_reg == (AW+1)'(EBUF_DEPTH));
  assign ebuf_wr = far_loop && des_word.vld && !ebuf_full;
  assign ebuf_rd = far_loop && tx_load && !ebuf_empty;
  always_comb begin
    wp_next = ebuf_wr ? wp_reg + 1'b1 : wp_reg;
    rp_next = ebuf_rd ? rp_reg + 1'b1 : rp_reg;
    fill_next = fill_reg + (AW+1)'(ebuf_wr) - (AW+1)'(ebuf_rd);
    if (!far_loop) begin
      wp_next = '0;
      rp_next = '0;
      fill_next = '0;
    end
  end
  always_ff @(posedge CLK_I or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      wp_reg <= '0;
      rp_reg <= '0;
      fill_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      fill_reg <= fill_next;
    end
  end
  // storage entries, written when a looped rx word arrives
  for (genvar g = 0; g < EBUF_DEPTH; g++) begin : g_ebuf
    always_ff @(posedge CLK_I) begin
      if (ebuf_wr && wp_reg == AW'(g)) ebuf_mem[g] <= des_word.dat;
    end
  end

  // transmit word source chosen at each serializer load
  logic [6:0] gen_reg, gen_next;
  logic [16:0] gen_step;
  lbk_word_t src_word;
  logic user_take;
  assign gen_step = prbs_step(gen_reg, '0, 1'b0);
  always_comb begin
    user_take = 1'b0;
    if (far_loop) begin
      // rx groups go back verbatim, idle word sent while the buffer is empty; user word not taken
      src_word = ebuf_empty ? `LBK_IDLE_WORD : ebuf_mem[rp_reg];
    end else if (ctrl_reg.prbs_en) begin
      src_word = gen_step[9:0];
    end else if (TX_VALID_I) begin
      src_word = TX_WORD_I;
      user_take = 1'b1;
    end else begin
      src_word = `LBK_IDLE_WORD;
    end
    gen_next = (tx_load && ctrl_reg.prbs_en && !far_loop) ?
               gen_step[16:10] : gen_reg;
  end

  // serializer, lsb first
  lbk_word_t sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic sdat_reg, sdat_next;
  logic sclk_reg, sclk_next;
  logic oe_reg, oe_next;
  logic take_reg, take_next;
  logic stb_d_reg;
  assign tx_load = tx_stb && (cnt_reg == 4'h0);
  always_comb begin
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    sdat_next = sdat_reg;
    if (tx_stb) begin
      if (cnt_reg == 4'h0) begin
        sdat_next = src_word[0];
        sh_next = src_word >> 1;
        cnt_next = `LBK_LAST_BIT;
      end else begin
        sdat_next = sh_reg[0];
        sh_next = sh_reg >> 1;
        cnt_next = cnt_reg - 4'h1;
      end
    end
    sclk_next = tx_stb ? 1'b1 : (tx_low ? 1'b0 : sclk_reg);
    // analog side idle in near parallel loop; driven in near serial loop
    oe_next = (path != LBK_PATH_NE_PAR);
    if (!oe_next) begin
      sdat_next = 1'b0;
      sclk_next = 1'b0;
    end
    take_next = tx_load && user_take;
  end
  always_ff @(posedge CLK_I or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      sh_reg <= '0;
      cnt_reg <= 4'h0;
      sdat_reg <= 1'b0;
      sclk_reg <= 1'b0;
      oe_reg <= 1'b0;
      take_reg <= 1'b0;
      stb_d_reg <= 1'b0;
      gen_reg <= `LBK_PRBS_SEED;
    end else begin
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      sdat_reg <= sdat_next;
      sclk_reg <= sclk_next;
      oe_reg <= oe_next;
      take_reg <= take_next;
      stb_d_reg <= tx_stb;
      gen_reg <= gen_next;
    end
  end

  // deserializer with comma alignment
  logic des_stb;
  logic des_bit;
  lbk_word_t dsh_reg, dsh_next, dsh_new;
  logic [3:0] dcnt_reg, dcnt_next;
  logic algn_reg, algn_next;
  lbk_ctrl_s ctrl_d_reg;
  always_comb begin
    // near serial loop returns the transmitted bit internally
    if (path == LBK_PATH_NE_SER) begin
      des_stb = stb_d_reg;
      des_bit = sdat_reg;
    end else begin
      des_stb = rx_rise && (path != LBK_PATH_NE_PAR);
      des_bit = rx_dat_reg[1];
    end
    dsh_new = {des_bit, dsh_reg[9:1]};
    dsh_next = dsh_reg;
    dcnt_next = dcnt_reg;
    algn_next = algn_reg && (ctrl_d_reg == ctrl_reg);
    des_word = '{vld: 1'b0, dat: dsh_new};
    if (des_stb) begin
      dsh_next = dsh_new;
      if (dsh_new == `LBK_COMMA_NEG || dsh_new == `LBK_COMMA_POS) begin
        algn_next = 1'b1;
        dcnt_next = 4'h0;
        des_word.vld = 1'b1;
      end else if (algn_reg) begin
        dcnt_next = (dcnt_reg == `LBK_LAST_BIT) ? 4'h0 : dcnt_reg + 4'h1;
        des_word.vld = (dcnt_reg == `LBK_LAST_BIT);
      end
    end
  end
  always_ff @(posedge CLK_I or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      dsh_reg <= '0;
      dcnt_reg <= 4'h0;
      algn_reg <= 1'b0;
      ctrl_d_reg <= `LBK_CTRL_RESET;
    end else begin
      dsh_reg <= dsh_next;
      dcnt_reg <= dcnt_next;
      algn_reg <= algn_next;
      ctrl_d_reg <= ctrl_reg;
    end
  end

  // parallel receive output and prbs checker
  lbk_pword_s rxo_reg, rxo_next;
  logic [6:0] chk_reg, chk_next;
  logic [16:0] chk_step;
  logic [15:0] err_reg, err_next;
  logic err_hit;
  logic err_clr;
  assign chk_step = prbs_step(chk_reg, rxo_next.dat, 1'b1);
  assign err_clr = REG_WR_I && (REG_ADDR_I == `LBK_REG_ERRS);
  always_comb begin
    if (path == LBK_PATH_NE_PAR) begin
      rxo_next = '{vld: tx_load, dat: src_word};
    end else begin
      rxo_next = des_word;
    end
    err_hit = rxo_next.vld && ctrl_reg.prbs_en &&
              (chk_step[9:0] != rxo_next.dat);
    chk_next = (rxo_next.vld && ctrl_reg.prbs_en) ? chk_step[16:10] : chk_reg;
    err_next = err_clr ? 16'h0 : err_reg;
    // an error in the clearing cycle still counts
    if (err_hit && err_next != `LBK_ERR_MAX) err_next = err_next + 16'h1;
  end
  always_ff @(posedge CLK_I or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rxo_reg <= '0;
      chk_reg <= `LBK_PRBS_SEED;
      err_reg <= 16'h0;
    end else begin
      rxo_reg <= rxo_next;
      chk_reg <= chk_next;
      err_reg <= err_next;
    end
  end

  // register port: writes and one-cycle-late reads
  logic [31:0] rdata_reg, rdata_next;
  always_comb begin
    ctrl_next = ctrl_reg;
    if (REG_WR_I && REG_ADDR_I == `LBK_REG_CTRL) begin
      ctrl_next.mode = REG_WDATA_I[`LBK_CTRL_MODE_LO +: 3];
      ctrl_next.prbs_en = REG_WDATA_I[`LBK_CTRL_PRBS_BIT];
    end
    rdata_next = 32'h0;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        `LBK_REG_CTRL: rdata_next = {28'h0, ctrl_reg};
        `LBK_REG_STAT: rdata_next = {27'h0, ebuf_full, ebuf_empty,
                                     oe_reg, mode_rsvd, algn_reg};
        `LBK_REG_ERRS: rdata_next = {16'h0, err_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end
  always_ff @(posedge CLK_I or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ctrl_reg <= `LBK_CTRL_RESET;
      rdata_reg <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flops
  assign REG_RDATA_O = rdata_reg;
  assign TX_TAKE_O = take_reg;
  assign RX_WORD_O = rxo_reg.dat;
  assign RX_VALID_O = rxo_reg.vld;
  assign TX_SCLK_O = sclk_reg;
  assign TX_SDAT_O = sdat_reg;
  assign TX_OE_O = oe_reg;
endmodule : lbk_channel
`default_nettype wire

// *** include/lbk_map.svh ***
// register offsets, mode codes, patterns and timing for the loopback channel
`ifndef LBK_MAP_SVH
`define LBK_MAP_SVH
`define LBK_REG_CTRL 8'h00
`define LBK_REG_STAT 8'h04
`define LBK_REG_ERRS 8'h08
`define LBK_CTRL_MODE_LO 0
`define LBK_CTRL_PRBS_BIT 3
`define LBK_CTRL_RESET 4'h0
`define LBK_MODE_NORMAL 3'h0
`define LBK_MODE_NE_PAR 3'h1
`define LBK_MODE_NE_SER 3'h2
`define LBK_MODE_FE_SER 3'h4
`define LBK_MODE_FE_PAR 3'h6
`define LBK_COMMA_NEG 10'h0FA
`define LBK_COMMA_POS 10'h305
`define LBK_IDLE_WORD 10'h0FA
`define LBK_PRBS_SEED 7'h7F
`define LBK_BIT_NS 160
`define LBK_CLK_NS 8
`define LBK_BIT_CYC (`LBK_BIT_NS / `LBK_CLK_NS)
`define LBK_LAST_BIT 4'h9
`define LBK_ERR_MAX 16'hFFFF
`endif

// *** include/lbk_pkg.sv ***
// types shared by the loopback channel
package lbk_pkg;
  typedef logic [9:0] lbk_word_t;
  typedef struct packed {
    logic prbs_en;
    logic [2:0] mode;
  } lbk_ctrl_s;
  typedef struct packed {
    logic vld;
    lbk_word_t dat;
  } lbk_pword_s;
  typedef enum {
    LBK_PATH_NORMAL,
    LBK_PATH_NE_PAR,
    LBK_PATH_NE_SER,
    LBK_PATH_FE_SER,
    LBK_PATH_FE_PAR
  } lbk_path_e;
endpackage : lbk_pkg
